/* File: logic/spc_core.sv */
/*
 * Serial control port front end with the configuration, readback select and commit registers.
 * Assumes serial pins are synchronous to core_clk and sclk is slower than core_clk / 2.
 */
`timescale 1ns/1ps
module spc_core (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic serial_read_out_pin,
   output logic serial_read_out_oe,
   output logic [7:0] pd_sync_active,
   output logic soft_reset_active,
   output logic commit_pulse
);

   spc_pkg::spc_state_e state_reg;
   logic sclk_reg, rise, fall;
   logic [3:0] bitcnt_reg;
   logic [15:0] in_sr_reg, in_next, instr;
   logic [12:0] addr_reg, addr_step, rd_addr;
   logic [1:0] left_reg;
   logic [7:0] cfg_reg, readback_reg, commit_reg, out_sr_reg, wr_byte, rd_byte, bank_rd;
   logic [3:0] cfg_eff;
   logic wr_fire, cfg_wr, regs_rst, instr_end, out_bit;
   spc_pkg::spc_wr_s bank_wr;

   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [15:0] w;
      w = spc_pkg::spc_rev16({v, 8'h00});
      return w[7:0];
   endfunction

   // Either half of the mirrored byte switches a function on, so shift order cannot flip it
   assign cfg_eff = cfg_reg[7:4] | {cfg_reg[0], cfg_reg[1], cfg_reg[2], cfg_reg[3]};
   assign rise = sclk & ~sclk_reg;
   assign fall = ~sclk & sclk_reg;
   assign in_next = {in_sr_reg[14:0], sdio_in};
   assign instr = cfg_eff[spc_pkg::EFF_LSB_FIRST] ? spc_pkg::spc_rev16(in_next) : in_next;
   assign wr_byte = cfg_eff[spc_pkg::EFF_LSB_FIRST] ? rev8(in_next[7:0]) : in_next[7:0];
   assign addr_step = cfg_eff[spc_pkg::EFF_LSB_FIRST] ? addr_reg + 13'h0001 : addr_reg - 13'h0001;
   assign instr_end = ce && !cs_n && rise && state_reg == spc_pkg::SPC_INSTR && bitcnt_reg == spc_pkg::INSTR_LAST_BIT;
   assign wr_fire = ce && !cs_n && rise && state_reg == spc_pkg::SPC_WRITE
      && bitcnt_reg == spc_pkg::BYTE_LAST_BIT;
   assign cfg_wr = wr_fire && addr_reg == spc_pkg::ADDR_CONFIG;
   assign regs_rst = sys_rst || soft_reset_active;
   assign rd_addr = instr_end ? instr[12:0] : addr_step;
   assign out_bit = cfg_eff[spc_pkg::EFF_LSB_FIRST] ? out_sr_reg[0] : out_sr_reg[7];
   assign bank_wr.en = wr_fire && (addr_reg == spc_pkg::ADDR_PD_SYNC || addr_reg == spc_pkg::ADDR_RSVD_SYS);
   assign bank_wr.idx = spc_pkg::spc_idx_t'(addr_reg == spc_pkg::ADDR_RSVD_SYS);
   assign bank_wr.data = wr_byte;

   always_comb
   begin
      if (rd_addr == spc_pkg::ADDR_CONFIG)
         rd_byte = cfg_reg;
      else if (rd_addr == spc_pkg::ADDR_READBACK)
         rd_byte = readback_reg;
      else if (rd_addr == spc_pkg::ADDR_PD_SYNC || rd_addr == spc_pkg::ADDR_RSVD_SYS)
         rd_byte = bank_rd;
      else if (rd_addr == spc_pkg::ADDR_COMMIT)
         rd_byte = commit_reg;
      else
         rd_byte = 8'h00;
   end

   spc_bank spc_bank_inst (
      .clk(core_clk),
      .ce(ce),
      .rst(regs_rst),
      .wr(bank_wr),
      .commit(commit_reg[spc_pkg::COMMIT_BIT]),
      .rd_idx(spc_pkg::spc_idx_t'(rd_addr == spc_pkg::ADDR_RSVD_SYS)),
      .rd_active(readback_reg[spc_pkg::READBACK_ACTIVE_BIT]),
      .rd_data(bank_rd),
      .act0(pd_sync_active)
   );

   // Frame sequencer; cs_n high abandons any partial byte
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= spc_pkg::SPC_INSTR;
         sclk_reg <= 1'b0;
         bitcnt_reg <= 4'h0;
         in_sr_reg <= 16'h0000;
         addr_reg <= 13'h0000;
         left_reg <= 2'b00;
      end
      else if (ce)
      begin
         sclk_reg <= sclk;
         if (cs_n)
         begin
            state_reg <= spc_pkg::SPC_INSTR;
            bitcnt_reg <= 4'h0;
         end
         else if (rise)
         begin
            in_sr_reg <= in_next;
            case (state_reg)
               spc_pkg::SPC_INSTR:
                  // Always a 16-bit instruction; the short form is not decoded
                  if (bitcnt_reg == spc_pkg::INSTR_LAST_BIT)
                  begin
                     addr_reg <= instr[12:0];
                     left_reg <= instr[spc_pkg::INSTR_LEN_MSB:spc_pkg::INSTR_LEN_LSB];
                     state_reg <= instr[spc_pkg::INSTR_READ_BIT] ? spc_pkg::SPC_READ : spc_pkg::SPC_WRITE;
                     bitcnt_reg <= 4'h0;
                  end
                  else
                     bitcnt_reg <= bitcnt_reg + 4'h1;
               spc_pkg::SPC_WRITE, spc_pkg::SPC_READ:
                  if (bitcnt_reg == spc_pkg::BYTE_LAST_BIT)
                  begin
                     bitcnt_reg <= 4'h0;
                     addr_reg <= addr_step;
                     if (left_reg == 2'b00)
                        state_reg <= spc_pkg::SPC_DONE;
                     else
                        left_reg <= left_reg - 2'b01;
                  end
                  else
                     bitcnt_reg <= bitcnt_reg + 4'h1;
               default:
                  state_reg <= spc_pkg::SPC_DONE;
            endcase
         end
      end
   end

   // Read data: load on the closing rising edge, drive on each falling edge
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         out_sr_reg <= 8'h00;
         sdio_out <= 1'b0;
         sdio_oe <= 1'b0;
         serial_read_out_pin <= 1'b0;
         serial_read_out_oe <= 1'b0;
      end
      else if (ce)
      begin
         if (cs_n || state_reg != spc_pkg::SPC_READ && !instr_end)
         begin
            sdio_oe <= 1'b0;
            serial_read_out_oe <= 1'b0;
         end
         if (!cs_n && rise && (instr_end && instr[spc_pkg::INSTR_READ_BIT]
             || state_reg == spc_pkg::SPC_READ && bitcnt_reg == spc_pkg::BYTE_LAST_BIT && left_reg != 2'b00))
            out_sr_reg <= rd_byte;
         else if (!cs_n && fall && state_reg == spc_pkg::SPC_READ)
         begin
            out_sr_reg <= cfg_eff[spc_pkg::EFF_LSB_FIRST] ? {1'b0, out_sr_reg[7:1]} : {out_sr_reg[6:0], 1'b0};
            if (cfg_eff[spc_pkg::EFF_READ_PIN])
            begin
               serial_read_out_pin <= out_bit;
               serial_read_out_oe <= 1'b1;
               sdio_oe <= 1'b0;
            end
            else
            begin
               sdio_out <= out_bit;
               sdio_oe <= 1'b1;
               serial_read_out_oe <= 1'b0;
            end
         end
      end
   end

   // Config is outside the soft reset so the host can write the reset bit back to 0
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         cfg_reg <= spc_pkg::CONFIG_RESET;
         soft_reset_active <= 1'b0;
      end
      else if (ce)
      begin
         if (cfg_wr)
            cfg_reg <= wr_byte;
         soft_reset_active <= cfg_eff[spc_pkg::EFF_SOFT_RST];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (regs_rst)
         readback_reg <= spc_pkg::READBACK_RESET;
      else if (ce && wr_fire && addr_reg == spc_pkg::ADDR_READBACK)
         readback_reg <= wr_byte;
   end

   // A new write wins over the self-clear in the same cycle
   always_ff @(posedge core_clk)
   begin
      if (regs_rst)
         commit_reg <= spc_pkg::COMMIT_RESET;
      else if (ce && wr_fire && addr_reg == spc_pkg::ADDR_COMMIT)
         commit_reg <= wr_byte & 8'h01;
      else if (ce)
         commit_reg <= 8'h00;
   end

   assign commit_pulse = commit_reg[spc_pkg::COMMIT_BIT];

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_READ_PIN_OFF_BIDIR: assert property (serial_read_out_oe
      |-> cfg_eff[spc_pkg::EFF_READ_PIN] && !sdio_oe)
      else $error("read pin driven in bidirectional mode");
   AST_DATA_PIN_OFF_UNI: assert property (sdio_oe |-> !cfg_eff[spc_pkg::EFF_READ_PIN])
      else $error("data pin driven in unidirectional mode");
   AST_MSB_FIRST_OUT: assert property (ce && !cs_n && fall && state_reg == spc_pkg::SPC_READ
      && !cfg_eff[spc_pkg::EFF_LSB_FIRST] && !cfg_eff[spc_pkg::EFF_READ_PIN]
      |=> sdio_out == $past(out_sr_reg[7]))
      else $error("msb first read shifted wrong bit");
   AST_ADDR_INCREMENT: assert property (wr_fire && cfg_eff[spc_pkg::EFF_LSB_FIRST]
      |=> addr_reg == $past(addr_reg) + 13'h0001)
      else $error("lsb first write did not increment address");
   AST_SOFT_RESET_DEFAULTS: assert property (soft_reset_active
      |=> readback_reg == spc_pkg::READBACK_RESET && pd_sync_active == spc_pkg::PD_SYNC_RESET)
      else $error("soft reset did not restore defaults");
   // The flag trails a config write by two edges, so both of them are excused
   AST_SOFT_RESET_STICKS: assert property (soft_reset_active && !cfg_wr && !$past(cfg_wr)
      |=> soft_reset_active)
      else $error("soft reset cleared itself");
   AST_LONG_INSTR_ONLY: assert property (ce && !cs_n && rise && state_reg == spc_pkg::SPC_INSTR
      && bitcnt_reg != spc_pkg::INSTR_LAST_BIT |=> state_reg == spc_pkg::SPC_INSTR)
      else $error("instruction ended before 16 bits");
   AST_MIRROR_EITHER_HALF: assert property (cfg_wr && (wr_byte[0] || wr_byte[7])
      |=> cfg_eff[spc_pkg::EFF_READ_PIN])
      else $error("mirrored read pin bit not honoured");
   AST_COMMIT_SELF_CLEAR: assert property (ce && commit_pulse && !wr_fire |=> !commit_pulse)
      else $error("update bit did not self-clear");
   AST_WHOLE_BYTE_ONLY: assert property ($changed(readback_reg) |-> $past(wr_fire) || $past(regs_rst))
      else $error("readback select changed on partial byte");

   COV_READ: cover property (instr_end ##[1:300] sdio_oe);
   COV_COMMIT: cover property (commit_pulse);
   COV_SOFT_RESET: cover property (soft_reset_active ##[1:1000] !soft_reset_active);
   COV_LSB_WRITE: cover property (wr_fire && cfg_eff[spc_pkg::EFF_LSB_FIRST]);

endmodule

/* File: logic/spc_pkg.sv */
/*
 * Package for the serial port configuration and update block: addresses, field positions,
 * reset values, transfer states, the write carrier and a bit reversal helper.
 * Assumes a 13-bit register address carried in a 16-bit instruction word.
 */
package spc_pkg;

   localparam logic [12:0] ADDR_CONFIG = 13'h000;
   localparam logic [12:0] ADDR_READBACK = 13'h004;
   localparam logic [12:0] ADDR_PD_SYNC = 13'h230;
   localparam logic [12:0] ADDR_RSVD_SYS = 13'h231;
   localparam logic [12:0] ADDR_COMMIT = 13'h232;

   // Positions inside the effective configuration nibble {read pin, lsb first, soft reset, long}
   localparam int EFF_READ_PIN = 3;
   localparam int EFF_LSB_FIRST = 2;
   localparam int EFF_SOFT_RST = 1;
   localparam int EFF_LONG_INSTR = 0;
   localparam int READBACK_ACTIVE_BIT = 0;
   localparam int COMMIT_BIT = 0;

   localparam logic [7:0] CONFIG_RESET = 8'h18;
   localparam logic [7:0] READBACK_RESET = 8'h00;
   localparam logic [7:0] PD_SYNC_RESET = 8'h00;
   localparam logic [7:0] RSVD_SYS_RESET = 8'h00;
   localparam logic [7:0] COMMIT_RESET = 8'h00;

   localparam int INSTR_READ_BIT = 15;
   localparam int INSTR_LEN_MSB = 14;
   localparam int INSTR_LEN_LSB = 13;
   localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
   localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
   localparam int BANK_DEPTH = 2;

   typedef enum logic [1:0] {SPC_INSTR, SPC_WRITE, SPC_READ, SPC_DONE} spc_state_e;
   typedef logic [0:0] spc_idx_t;

   typedef struct packed {
      logic en;
      spc_idx_t idx;
      logic [7:0] data;
   } spc_wr_s;

   function automatic logic [15:0] spc_rev16(input logic [15:0] v);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 16; i++)
      begin
         r[i] = v[15 - i];
      end
      return r;
   endfunction

endpackage

/* File: logic/spc_bank.sv */
/*
 * Buffered and active copies of the committed settings bytes.
 * Assumes the caller decodes addresses and pulses commit for one enabled cycle.
 */
`timescale 1ns/1ps
module spc_bank (
   input wire logic clk,
   input wire logic ce,
   input wire logic rst,
   input spc_pkg::spc_wr_s wr,
   input wire logic commit,
   input spc_pkg::spc_idx_t rd_idx,
   input wire logic rd_active,
   output logic [7:0] rd_data,
   output logic [7:0] act0
);

   logic [7:0] buf_reg [spc_pkg::BANK_DEPTH];
   logic [7:0] act_reg [spc_pkg::BANK_DEPTH];

   // Writes only touch the buffer; the reserved slot never stores
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         buf_reg[0] <= spc_pkg::PD_SYNC_RESET;
         buf_reg[1] <= spc_pkg::RSVD_SYS_RESET;
      end
      else if (ce && wr.en && wr.idx == 1'b0)
      begin
         buf_reg[wr.idx] <= wr.data;
      end
   end

   // All buffers move to the active side in the same edge
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         act_reg[0] <= spc_pkg::PD_SYNC_RESET;
         act_reg[1] <= spc_pkg::RSVD_SYS_RESET;
      end
      else if (ce && commit)
      begin
         for (int i = 0; i < spc_pkg::BANK_DEPTH; i++)
         begin
            act_reg[i] <= buf_reg[i];
         end
      end
   end

   assign rd_data = rd_active ? act_reg[rd_idx] : buf_reg[rd_idx];
   assign act0 = act_reg[0];

   AST_COMMIT_COPIES: assert property (@(posedge clk) disable iff (rst)
      ce && commit |=> act_reg[0] == $past(buf_reg[0]))
      else $error("commit did not copy buffer to active");
   AST_BUFFER_ISOLATED: assert property (@(posedge clk) disable iff (rst)
      !commit |=> act_reg[0] == $past(act_reg[0]))
      else $error("active register changed without commit");
   AST_READBACK_SOURCE: assert property (@(posedge clk) disable iff (rst)
      rd_idx == 1'b0 && !rd_active |-> rd_data == buf_reg[0])
      else $error("buffer readback returned wrong bank");

endmodule

/* File: tb/spc_host_model.sv */
/*
 * Host controller model that frames serial transfers for the configuration block.
 * Assumes it is called between core_clk rising edges and that sclk idles low outside frames.
 */
`timescale 1ns/1ps
module spc_host_model (
   input wire logic core_clk,
   output logic sclk,
   output logic cs_n,
   output logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic serial_read_out_pin,
   input wire logic serial_read_out_oe
);
   logic drv;
   logic bitv;
   logic tog;
   int bad_oe;
   // Released data line shows a changing pattern, never the last bit
   assign sdio_in = sdio_oe ? sdio_out : (drv ? bitv : tog);
   initial
   begin
      sclk = 1'h0;
      cs_n = 1'h1;
      drv = 1'h0;
      bitv = 1'h0;
      tog = 1'h0;
      bad_oe = 0;
   end
   always @(posedge core_clk) tog <= ~tog;

   // Low phase is three cycles so a read bit is sampled after its output flop settles
   task automatic clk_bit(input logic b, input logic d, input logic sep, output logic s);
      bitv <= b;
      drv <= d;
      sclk <= 1'h0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      s = sep ? serial_read_out_pin : sdio_out;
      if (!d && (sep ? !(serial_read_out_oe === 1'h1 && sdio_oe === 1'h0)
                     : !(sdio_oe === 1'h1 && serial_read_out_oe === 1'h0)))
         bad_oe++;
      @(posedge core_clk);
      sclk <= 1'h1;
      repeat (2) @(posedge core_clk);
   endtask

   // Sends nb data bits; byte i sits in wd[8*i+:8]; every unit shifts in the same order
   task automatic frame(input logic rd, input logic [1:0] wl, input logic [12:0] addr, input logic [31:0] wd,
                        input int nb, input logic lsb, input logic sep, output logic [31:0] rdv);
      logic [15:0] ins;
      logic s;
      int k;
      ins = {rd, wl, addr};
      rdv = 32'h0;
      @(posedge core_clk);
      cs_n <= 1'h0;
      for (int i = 0; i < 16; i++)
         clk_bit(ins[lsb ? i : 15 - i], 1'h1, sep, s);
      for (int i = 0; i < nb; i++)
      begin
         k = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
         clk_bit(wd[k], !rd, sep, s);
         rdv[k] = s;
      end
      cs_n <= 1'h1;
      drv <= 1'h0;
      sclk <= 1'h0;
      repeat (4) @(posedge core_clk);
   endtask
endmodule

/* File: tb/spc_core_test.sv */
/*
 * Self-checking bench for the serial configuration and update block.
 * Assumes the host model frames all serial traffic and ce is held high except during the frozen core check.
 */
`timescale 1ns/1ps
module spc_core_test;
   typedef struct packed {
      logic rd;
      logic [12:0] addr;
      logic [7:0] val;
      logic [7:0] pd;
   } spc_row_s;
   logic core_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic ce = 1'h1;
   logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, serial_read_out_pin, serial_read_out_oe;
   logic soft_reset_active, commit_pulse;
   logic [7:0] pd_sync_active;
   logic [7:0] v;
   logic [31:0] r;
   logic lsb_m = 1'h0;
   logic sep_m = 1'h0;
   int num_errors = 0;
   int tests_run = 0;
   int pulses = 0;
   int p0;
   spc_row_s rows [15] = '{
      '{1'h1, 13'h000, 8'h18, 8'h00}, '{1'h1, 13'h004, 8'h00, 8'h00}, '{1'h1, 13'h232, 8'h00, 8'h00},
      '{1'h1, 13'h231, 8'h00, 8'h00}, '{1'h0, 13'h230, 8'ha5, 8'h00}, '{1'h1, 13'h230, 8'ha5, 8'h00},
      '{1'h0, 13'h231, 8'h5a, 8'h00}, '{1'h1, 13'h231, 8'h00, 8'h00}, '{1'h1, 13'h100, 8'h00, 8'h00},
      '{1'h0, 13'h004, 8'h01, 8'h00}, '{1'h1, 13'h230, 8'h00, 8'h00}, '{1'h0, 13'h232, 8'h01, 8'ha5},
      '{1'h1, 13'h230, 8'ha5, 8'ha5}, '{1'h1, 13'h232, 8'h00, 8'ha5}, '{1'h0, 13'h004, 8'h00, 8'ha5}};

   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) if (commit_pulse === 1'h1) pulses <= pulses + 1;

   spc_core spc_core_inst (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .sclk(sclk), .cs_n(cs_n),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_read_out_pin(serial_read_out_pin),
      .serial_read_out_oe(serial_read_out_oe), .pd_sync_active(pd_sync_active),
      .soft_reset_active(soft_reset_active), .commit_pulse(commit_pulse));
   spc_host_model spc_host_model_inst (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_read_out_pin(serial_read_out_pin),
      .serial_read_out_oe(serial_read_out_oe));

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e)
      begin
         num_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic conclude();
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Host keeps bits 3..0 mirrored in every config byte it writes
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      spc_host_model_inst.frame(1'h0, 2'h0, a, {24'h0, d}, 8, lsb_m, sep_m, r);
   endtask
   task automatic rd(input logic [12:0] a, output logic [7:0] d);
      spc_host_model_inst.frame(1'h1, 2'h0, a, 32'h0, 8, lsb_m, sep_m, r);
      d = r[7:0];
   endtask

   initial
   begin
      repeat (60000) @(posedge core_clk);
      num_errors++;
      conclude();
   end

   initial
   begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'h0;
      @(posedge core_clk);
      chk({soft_reset_active, commit_pulse, 6'h0}, 8'h00);
      chk(pd_sync_active, spc_pkg::PD_SYNC_RESET);
      foreach (rows[i])
      begin
         if (rows[i].rd)
         begin
            rd(rows[i].addr, v);
            chk(v, rows[i].val);
         end
         else
            wr(rows[i].addr, rows[i].val);
         chk(pd_sync_active, rows[i].pd);
      end
      chk(pulses[7:0], 8'h01);
      // Two-byte write from 0x231 steps down onto 0x230
      spc_host_model_inst.frame(1'h0, 2'h1, 13'h231, 32'h6611, 16, 1'h0, 1'h0, r);
      spc_host_model_inst.frame(1'h1, 2'h1, 13'h231, 32'h0, 16, 1'h0, 1'h0, r);
      chk(r[15:8], 8'h66);
      chk(r[7:0], 8'h00);
      wr(13'h000, 8'h99);
      sep_m = 1'h1;
      rd(13'h230, v);
      chk(v, 8'h66);
      wr(13'h000, 8'h18);
      sep_m = 1'h0;
      rd(13'h230, v);
      chk(v, 8'h66);
      chk(spc_host_model_inst.bad_oe[7:0], 8'h00);
      wr(13'h000, 8'h5a);
      lsb_m = 1'h1;
      spc_host_model_inst.frame(1'h0, 2'h1, 13'h22f, 32'h7700, 16, 1'h1, 1'h0, r);
      spc_host_model_inst.frame(1'h1, 2'h1, 13'h230, 32'h0, 16, 1'h1, 1'h0, r);
      chk(r[7:0], 8'h77);
      rd(13'h000, v);
      chk(v, 8'h5a);
      wr(13'h000, 8'h18);
      lsb_m = 1'h0;
      rd(13'h000, v);
      chk(v, 8'h18);
      wr(13'h232, 8'h01);
      wr(13'h004, 8'h01);
      chk(pd_sync_active, 8'h77);
      wr(13'h000, 8'h3c);
      chk({7'h0, soft_reset_active}, 8'h01);
      chk(pd_sync_active, 8'h00);
      wr(13'h230, 8'h44);
      repeat (20) @(posedge core_clk);
      chk({7'h0, soft_reset_active}, 8'h01);
      wr(13'h000, 8'h18);
      chk({7'h0, soft_reset_active}, 8'h00);
      rd(13'h004, v);
      chk(v, 8'h00);
      rd(13'h230, v);
      chk(v, 8'h00);
      // A commit byte cut after four bits must not fire
      wr(13'h230, 8'h44);
      p0 = pulses;
      spc_host_model_inst.frame(1'h0, 2'h0, 13'h232, 32'h01, 4, 1'h0, 1'h0, r);
      chk(pulses[7:0] - p0[7:0], 8'h00);
      chk(pd_sync_active, 8'h00);
      wr(13'h232, 8'h01);
      chk(pulses[7:0] - p0[7:0], 8'h01);
      chk(pd_sync_active, 8'h44);
      // Frozen core: neither a write nor a commit may land while ce is low
      ce <= 1'h0;
      wr(13'h230, 8'h12);
      wr(13'h232, 8'h01);
      ce <= 1'h1;
      chk(pulses[7:0] - p0[7:0], 8'h01);
      chk(pd_sync_active, 8'h44);
      rd(13'h230, v);
      chk(v, 8'h44);
      // Mid-run reset returns config, readback select and the bank to defaults
      wr(13'h004, 8'h01);
      wr(13'h000, 8'h99);
      sys_rst <= 1'h1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'h0;
      repeat (2) @(posedge core_clk);
      chk(pd_sync_active, spc_pkg::PD_SYNC_RESET);
      rd(13'h000, v);
      chk(v, spc_pkg::CONFIG_RESET);
      rd(13'h004, v);
      chk(v, spc_pkg::READBACK_RESET);
      conclude();
   end
endmodule
